// ==== core/wake_frame_detector.sv ====
// Wake frame detector top: registers, reporting and isolate
`timescale 1ns/10ps
`default_nettype none
module wake_frame_detector
    import wake_pkg::*;
(
    input wire logic core_clk_i,            // 250 MHz clock
    input wire logic resetn_i,              // Hardware reset, active low
    input wire logic reg_wr_i,              // Register write strobe
    input wire logic reg_rd_i,              // Register read strobe
    input wire logic [15:0] reg_addr_i,     // Register offset
    input wire logic [15:0] reg_wdata_i,    // Write data
    output logic [15:0] reg_rdata_o,        // Read data
    output logic reg_rvalid_o,              // Read data valid
    input wire logic rx_valid_i,            // Received byte valid
    input wire logic [7:0] rx_byte_i,       // Received byte
    input wire logic rx_frame_end_i,        // End of frame pulse
    input wire logic rx_frame_good_i,       // Frame passed checks
    input wire logic mac_tx_en_i,           // MAC transmit enable
    input wire logic [7:0] mac_tx_byte_i,   // MAC transmit byte
    input wire logic activity_i,            // Normal activity light level
    input wire logic wake_strap_pad_i,      // Strap for wake pin use
    output logic [7:0] mac_rx_byte_o,       // Byte toward MAC
    output logic mac_rx_valid_o,            // Byte valid toward MAC
    output logic mac_rx_oe_o,               // MAC outputs driven
    output logic [7:0] line_tx_byte_o,      // Byte toward line
    output logic line_tx_en_o,              // Transmit toward line
    output logic activity_light_pin_o,      // Activity or wake, low active wake
    output logic general_irq_pin_n_o,       // General interrupt, active low
    output logic remote_wake_o              // Wake event pulse
);
    logic [15:0] ctrl_q, ctrl_d;
    logic [15:0] ie_q, ie_d;
    logic [15:0] wctl_q, wctl_d;
    logic [15:0] wcfg_q, wcfg_d;
    logic [15:0] addr_hi_q, addr_hi_d;
    logic [15:0] addr_mid_q, addr_mid_d;
    logic [15:0] addr_lo_q, addr_lo_d;
    logic ist_q, ist_d;
    logic wstat_q, wstat_d;
    logic strap_q, strap_d;
    logic strap_done_q, strap_done_d;
    logic [15:0] rdata_d;
    logic rvalid_d;
    logic [7:0] mrx_byte_d, ltx_byte_d;
    logic mrx_valid_d, mrx_oe_d, ltx_en_d;
    logic act_pin_d, gen_n_d, wake_d;
    logic swrst, wstat_clr, irq_active, found;

    match_if mi ();

    // Feed the matcher with every received frame
    assign mi.station_addr = {addr_hi_q, addr_mid_q, addr_lo_q};
    assign mi.enable = wctl_q[WAKE_EN_BIT];
    assign mi.rx_valid = rx_valid_i;
    assign mi.rx_byte = rx_byte_i;
    assign mi.frame_end = rx_frame_end_i;
    assign mi.frame_good = rx_frame_good_i;
    assign found = mi.found;

    wake_matcher u_matcher (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .m(mi.matcher)
    );

    // Software clears wake status by writing one to its bit
    assign wstat_clr = reg_wr_i && reg_addr_i == OFS_WAKE_CONTROL && reg_wdata_i[WAKE_STAT_BIT];
    assign swrst = reg_wr_i && reg_addr_i == OFS_BASIC_CONTROL && reg_wdata_i[SWRESET_BIT];

    wake_irq_shaper u_shaper (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .event_i(found),
        .pulse_mode_i(wcfg_q[PULSE_MODE_BIT]),
        .width_sel_i(wcfg_q[PULSE_WIDTH_LSB +: 2]),
        .clear_i(wstat_clr),
        .active_o(irq_active)
    );

    // Register writes, read clear and event flags
    always_comb begin
        ctrl_d = ctrl_q;
        ie_d = ie_q;
        wctl_d = wctl_q;
        wcfg_d = wcfg_q;
        addr_hi_d = addr_hi_q;
        addr_mid_d = addr_mid_q;
        addr_lo_d = addr_lo_q;
        ist_d = ist_q;
        wstat_d = wstat_q;
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_BASIC_CONTROL: ctrl_d = reg_wdata_i;
                OFS_INT_ENABLE: ie_d = reg_wdata_i;
                OFS_WAKE_CONTROL: wctl_d = reg_wdata_i;
                OFS_WAKE_IRQ_CONFIG: wcfg_d = reg_wdata_i;
                OFS_ADDR_HI: addr_hi_d = reg_wdata_i;
                OFS_ADDR_MID: addr_mid_d = reg_wdata_i;
                OFS_ADDR_LO: addr_lo_d = reg_wdata_i;
                default: ctrl_d = ctrl_q;
            endcase
        end
        ctrl_d[SWRESET_BIT] = 1'b0; // Self clearing
        wctl_d[WAKE_STAT_BIT] = 1'b0; // Held in its own flag
        if (reg_rd_i && reg_addr_i == OFS_INT_STATUS) ist_d = 1'b0;
        if (wstat_clr) wstat_d = 1'b0;
        // An event in the clearing cycle is kept
        if (found) begin
            ist_d = 1'b1;
            wstat_d = 1'b1;
        end
        // Software reset restores defaults but keeps the strap
        if (swrst) begin
            ctrl_d = RESET_VALUE;
            ie_d = RESET_VALUE;
            wctl_d = RESET_VALUE;
            wcfg_d = RESET_VALUE;
            addr_hi_d = RESET_VALUE;
            addr_mid_d = RESET_VALUE;
            addr_lo_d = RESET_VALUE;
            ist_d = 1'b0;
            wstat_d = 1'b0;
        end
    end

    // Strap capture, first edge after hardware reset only
    always_comb begin
        strap_d = strap_q;
        strap_done_d = 1'b1;
        if (!strap_done_q) strap_d = wake_strap_pad_i;
    end

    // Read data mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 16'h0000;
        rvalid_d = reg_rd_i;
        if (reg_rd_i) begin
            case (reg_addr_i)
                OFS_BASIC_CONTROL: rdata_d = ctrl_q;
                OFS_INT_ENABLE: rdata_d = ie_q;
                OFS_INT_STATUS: rdata_d = 16'(ist_q) << WAKE_IE_BIT;
                OFS_WAKE_CONTROL: rdata_d = wctl_q | (16'(wstat_q) << WAKE_STAT_BIT);
                OFS_WAKE_IRQ_CONFIG: rdata_d = wcfg_q;
                OFS_ADDR_HI: rdata_d = addr_hi_q;
                OFS_ADDR_MID: rdata_d = addr_mid_q;
                OFS_ADDR_LO: rdata_d = addr_lo_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Pins; isolate floats MAC outputs and drops MAC inputs
    always_comb begin
        mrx_oe_d = !ctrl_q[ISOLATE_BIT];
        mrx_byte_d = rx_byte_i;
        mrx_valid_d = rx_valid_i && !ctrl_q[ISOLATE_BIT];
        ltx_en_d = mac_tx_en_i && !ctrl_q[ISOLATE_BIT];
        ltx_byte_d = ctrl_q[ISOLATE_BIT] ? 8'h00 : mac_tx_byte_i;
        act_pin_d = strap_q ? !irq_active : activity_i;
        // Wired-AND onto the general pin; level mode keeps it low past a read
        gen_n_d = !(ie_q[WAKE_IE_BIT] && (ist_q || (irq_active && !wcfg_q[PULSE_MODE_BIT])));
        wake_d = found;
    end

    // All registers, constants only under reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= RESET_VALUE;
            ie_q <= RESET_VALUE;
            wctl_q <= RESET_VALUE;
            wcfg_q <= RESET_VALUE;
            addr_hi_q <= RESET_VALUE;
            addr_mid_q <= RESET_VALUE;
            addr_lo_q <= RESET_VALUE;
            ist_q <= 1'b0;
            wstat_q <= 1'b0;
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
            reg_rdata_o <= 16'h0000;
            reg_rvalid_o <= 1'b0;
            mac_rx_byte_o <= 8'h00;
            mac_rx_valid_o <= 1'b0;
            mac_rx_oe_o <= 1'b0;
            line_tx_byte_o <= 8'h00;
            line_tx_en_o <= 1'b0;
            activity_light_pin_o <= 1'b0;
            general_irq_pin_n_o <= 1'b1;
            remote_wake_o <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ie_q <= ie_d;
            wctl_q <= wctl_d;
            wcfg_q <= wcfg_d;
            addr_hi_q <= addr_hi_d;
            addr_mid_q <= addr_mid_d;
            addr_lo_q <= addr_lo_d;
            ist_q <= ist_d;
            wstat_q <= wstat_d;
            strap_q <= strap_d;
            strap_done_q <= strap_done_d;
            reg_rdata_o <= rdata_d;
            reg_rvalid_o <= rvalid_d;
            mac_rx_byte_o <= mrx_byte_d;
            mac_rx_valid_o <= mrx_valid_d;
            mac_rx_oe_o <= mrx_oe_d;
            line_tx_byte_o <= ltx_byte_d;
            line_tx_en_o <= ltx_en_d;
            activity_light_pin_o <= act_pin_d;
            general_irq_pin_n_o <= gen_n_d;
            remote_wake_o <= wake_d;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_event_sets_flags: assert property (found && !swrst |=> ist_q && wstat_q && remote_wake_o) else $error("event not flagged");
    a_read_clears: assert property (reg_rd_i && reg_addr_i == OFS_INT_STATUS && !found |=> !ist_q) else $error("read did not clear");
    a_general_joined: assert property (ie_q[WAKE_IE_BIT] && ist_q |=> !general_irq_pin_n_o) else $error("general irq missing");
    a_general_idle: assert property (!ie_q[WAKE_IE_BIT] |=> general_irq_pin_n_o) else $error("general irq unmasked");
    a_isolate_floats: assert property (ctrl_q[ISOLATE_BIT] |=> !mac_rx_oe_o && !line_tx_en_o && !mac_rx_valid_o) else $error("isolate leak");
    a_strap_pin: assert property (strap_q && irq_active |=> !activity_light_pin_o) else $error("wake pin not low");
    a_strap_stable: assert property (strap_done_q |=> $stable(strap_q)) else $error("strap relatched");
    c_read_clear: cover property (ist_q ##1 reg_rd_i && reg_addr_i == OFS_INT_STATUS);
    c_isolate: cover property (ctrl_q[ISOLATE_BIT] && mac_tx_en_i);
endmodule
`default_nettype wire

// ==== core/wake_pkg.sv ====
// Constants and types shared by the wake frame detector
package wake_pkg;
    localparam logic [15:0] OFS_BASIC_CONTROL = 16'h0000;
    localparam logic [15:0] OFS_INT_ENABLE = 16'h0012;
    localparam logic [15:0] OFS_INT_STATUS = 16'h0013;
    localparam logic [15:0] OFS_WAKE_CONTROL = 16'h4000;
    localparam logic [15:0] OFS_WAKE_IRQ_CONFIG = 16'h4003;
    localparam logic [15:0] OFS_ADDR_HI = 16'h4004;
    localparam logic [15:0] OFS_ADDR_MID = 16'h4005;
    localparam logic [15:0] OFS_ADDR_LO = 16'h4006;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam int SWRESET_BIT = 15;
    localparam int ISOLATE_BIT = 10;
    localparam int WAKE_IE_BIT = 6;
    localparam int WAKE_EN_BIT = 2;
    localparam int WAKE_STAT_BIT = 15;
    localparam int PULSE_MODE_BIT = 7;
    localparam int PULSE_WIDTH_LSB = 8;
    localparam logic [7:0] SYNC_BYTE = 8'hff;
    localparam int SYNC_LEN = 6;
    localparam int ADDR_BYTES = 6;
    localparam int COPIES = 16;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PULSE_UNIT_NS = 1000;
    localparam int PULSE_UNIT_CYC = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {M_SYNC, M_ADDR, M_HIT} match_state_t;
endpackage

// ==== core/match_if.sv ====
// Link between register block and pattern matcher
`timescale 1ns/10ps
`default_nettype none
interface match_if;
    logic [47:0] station_addr;
    logic enable;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic frame_end;
    logic frame_good;
    logic found;
    modport top (output station_addr, enable, rx_valid, rx_byte, frame_end, frame_good, input found);
    modport matcher (input station_addr, enable, rx_valid, rx_byte, frame_end, frame_good, output found);
endinterface
`default_nettype wire

// ==== core/wake_matcher.sv ====
// Byte-wise search for the sync run and address copies
`timescale 1ns/10ps
`default_nettype none
module wake_matcher
    import wake_pkg::*;
(
    input wire logic core_clk_i, // 250 MHz clock
    input wire logic resetn_i,   // Async reset, active low
    match_if.matcher m           // Stream and result
);
    match_state_t state_q, state_d;
    logic [2:0] sync_q, sync_d;
    logic [2:0] idx_q, idx_d;
    logic [3:0] copy_q, copy_d;
    logic found_q, found_d;
    logic [7:0] exp_byte;

    assign m.found = found_q;

    // Next state; frames are not filtered before the search
    always_comb begin
        state_d = state_q;
        sync_d = sync_q;
        idx_d = idx_q;
        copy_d = copy_q;
        found_d = 1'b0;
        exp_byte = m.station_addr[47 - 8 * idx_q -: 8]; // First byte from high register
        if (!m.enable) begin
            state_d = M_SYNC;
            sync_d = 3'd0;
            idx_d = 3'd0;
        end else if (m.frame_end) begin
            // Only a good frame may report; partial matches die here
            found_d = (state_q == M_HIT) && m.frame_good;
            state_d = M_SYNC;
            sync_d = 3'd0;
            idx_d = 3'd0;
        end else if (m.rx_valid) begin
            case (state_q)
                M_SYNC: begin // Any bytes may precede the sync run
                    if (sync_q == 3'(SYNC_LEN) && m.rx_byte == exp_byte) begin
                        state_d = M_ADDR;
                        idx_d = 3'd1;
                        copy_d = 4'd0;
                    end else if (m.rx_byte == SYNC_BYTE) begin
                        sync_d = (sync_q == 3'(SYNC_LEN)) ? sync_q : sync_q + 3'd1; // Longer runs still count
                    end else begin
                        sync_d = 3'd0;
                    end
                end
                M_ADDR: begin
                    if (m.rx_byte == exp_byte) begin // Copies must be unbroken
                        if (idx_q == 3'(ADDR_BYTES - 1)) begin
                            idx_d = 3'd0;
                            if (copy_q == 4'(COPIES - 1)) state_d = M_HIT;
                            else copy_d = copy_q + 4'd1;
                        end else begin
                            idx_d = idx_q + 3'd1;
                        end
                    end else begin // Restart, a breaking 0xff starts a new run
                        state_d = M_SYNC;
                        sync_d = (m.rx_byte == SYNC_BYTE) ? 3'd1 : 3'd0;
                        idx_d = 3'd0; // Next search compares the first address byte
                    end
                end
                M_HIT: state_d = M_HIT; // Trailing bytes are allowed
                default: state_d = M_SYNC;
            endcase
        end
    end

    // State registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= M_SYNC;
            sync_q <= 3'd0;
            idx_q <= 3'd0;
            copy_q <= 4'd0;
            found_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sync_q <= sync_d;
            idx_q <= idx_d;
            copy_q <= copy_d;
            found_q <= found_d;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_found_good_frame: assert property (m.found |-> $past(m.frame_end && m.frame_good)) else $error("found without good frame");
    a_found_needs_hit: assert property (m.found |-> $past(state_q) == M_HIT) else $error("found without full pattern");
    a_disabled_silent: assert property (!m.enable |=> !m.found && state_q == M_SYNC) else $error("found while disabled");
    a_end_discards: assert property (m.enable && m.frame_end |=> state_q == M_SYNC && sync_q == 3'd0) else $error("partial kept");
    a_sync_from_top: assert property (state_q == M_SYNC |-> idx_q == 3'd0) else $error("stale address index");
    c_pattern_found: cover property (m.found);
endmodule
`default_nettype wire

// ==== core/wake_irq_shaper.sv ====
// Level or pulse shaping of the wake interrupt
`timescale 1ns/10ps
`default_nettype none
module wake_irq_shaper
    import wake_pkg::*;
(
    input wire logic core_clk_i,       // 250 MHz clock
    input wire logic resetn_i,         // Async reset, active low
    input wire logic event_i,          // Wake frame seen, pulse
    input wire logic pulse_mode_i,     // 1 pulse, 0 level
    input wire logic [1:0] width_sel_i,// Pulse width select
    input wire logic clear_i,          // Software cleared status
    output logic active_o              // Interrupt asserted, high
);
    logic level_q, level_d;
    logic [11:0] cnt_q, cnt_d;
    logic [11:0] pw_cyc;

    // Width grows in whole units so the host sees at least one unit
    assign pw_cyc = 12'(({10'd0, width_sel_i} + 12'd1) * 12'(PULSE_UNIT_CYC));
    assign active_o = level_q || (cnt_q != 12'd0);

    // Next values; a new event wins over a clear
    always_comb begin
        level_d = 1'b0;
        cnt_d = 12'd0;
        if (pulse_mode_i) begin
            if (event_i) cnt_d = pw_cyc;
            else if (cnt_q != 12'd0) cnt_d = cnt_q - 12'd1;
        end else begin
            level_d = event_i || (level_q && !clear_i);
        end
    end

    // Registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            level_q <= 1'b0;
            cnt_q <= 12'd0;
        end else begin
            level_q <= level_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_pulse_width: assert property (pulse_mode_i && event_i |=> cnt_q == $past(pw_cyc)) else $error("pulse width wrong");
    a_level_holds: assert property (!pulse_mode_i && level_q && !clear_i |=> active_o) else $error("level dropped early");
    c_pulse_seen: cover property (pulse_mode_i && event_i ##1 active_o [*3]);
endmodule
`default_nettype wire

// ==== verif/frame_source.sv ====
// Partner model: frame source feeding the receive byte stream
`timescale 1ns/10ps
`default_nettype none
module frame_source (
    input wire logic core_clk_i, // Receive clock
    output logic rx_valid_o,     // Byte valid
    output logic [7:0] rx_byte_o,// Received byte
    output logic frame_end_o,    // End of frame pulse
    output logic frame_good_o    // Frame passed checks
);
    logic [7:0] fq[$];
    // Idle stream at time zero
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        frame_end_o = 1'b0;
        frame_good_o = 1'b0;
    end
    // Send queued bytes with gap idle cycles between them; idle data is inverted so it never looks held
    task automatic send(input bit good, input int gap);
        int i;
        for (i = 0; i < fq.size(); i++) begin
            @(posedge core_clk_i);
            rx_valid_o <= 1'b1;
            rx_byte_o <= fq[i];
            repeat (gap) begin
                @(posedge core_clk_i);
                rx_valid_o <= 1'b0;
                rx_byte_o <= ~fq[i];
            end
        end
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= 8'h5a;
        frame_end_o <= 1'b1;
        frame_good_o <= good;
        @(posedge core_clk_i);
        frame_end_o <= 1'b0;
        frame_good_o <= 1'b0;
        fq.delete();
    endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the wake frame detector
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import wake_pkg::*;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000, reg_rdata_o;
    logic reg_rvalid_o, rx_valid_i, rx_frame_end_i, rx_frame_good_i, mac_rx_valid_o, mac_rx_oe_o;
    logic [7:0] rx_byte_i, mac_rx_byte_o, line_tx_byte_o, mac_tx_byte_i = 8'h00;
    logic mac_tx_en_i = 1'b0, activity_i = 1'b0, wake_strap_pad_i = 1'b1;
    logic line_tx_en_o, activity_light_pin_o, general_irq_pin_n_o, remote_wake_o;
    logic [47:0] addr;
    logic [7:0] rx_prev;
    logic [15:0] exp_q[$], msk_q[$];
    logic [15:0] offs[8] = '{16'h0000, 16'h0012, 16'h0013, 16'h4000, 16'h4003, 16'h4004, 16'h4005, 16'h4006};
    int fails = 0, n_tests = 0, wake_n = 0, low_n = 0, rxv_n = 0, w, k;

    always #2 core_clk_i = ~core_clk_i;

    wake_frame_detector dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
        .rx_frame_end_i(rx_frame_end_i), .rx_frame_good_i(rx_frame_good_i), .mac_tx_en_i(mac_tx_en_i),
        .mac_tx_byte_i(mac_tx_byte_i), .activity_i(activity_i), .wake_strap_pad_i(wake_strap_pad_i),
        .mac_rx_byte_o(mac_rx_byte_o), .mac_rx_valid_o(mac_rx_valid_o), .mac_rx_oe_o(mac_rx_oe_o),
        .line_tx_byte_o(line_tx_byte_o), .line_tx_en_o(line_tx_en_o),
        .activity_light_pin_o(activity_light_pin_o), .general_irq_pin_n_o(general_irq_pin_n_o),
        .remote_wake_o(remote_wake_o));
    frame_source src (.core_clk_i(core_clk_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
        .frame_end_o(rx_frame_end_i), .frame_good_o(rx_frame_good_i));

    task automatic fail_msg(input string s);
        $display("ERROR %0t %s", $time, s);
        fails++;
    endtask
    task automatic check(input logic c, input string s);
        n_tests++;
        if (c !== 1'b1) fail_msg(s);
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Register cycles: one-cycle strobes, reads leave a note for the monitor
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask
    // Frame building: filler never holds the sync byte so it cannot start a run
    task automatic add_misc(input int n);
        repeat (n) src.fq.push_back(8'($urandom % 255));
    endtask
    task automatic add_pat(input int nsync, input int ncopies);
        int i;
        for (i = 0; i < nsync; i++) src.fq.push_back(SYNC_BYTE);
        for (i = 0; i < ncopies * ADDR_BYTES; i++) src.fq.push_back(addr[47 - 8 * (i % 6) -: 8]);
    endtask
    task automatic go(input bit good, input int gap, input int exp);
        add_misc(4);
        #1 wake_n = 0;
        low_n = 0;
        src.send(good, gap);
        repeat (10) @(posedge core_clk_i);
        check(wake_n == exp, "wake report count wrong");
    endtask

    // Read monitor compares each answer with the oldest note
    always @(posedge core_clk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            n_tests++;
            if (exp_q.size() == 0) begin
                fail_msg("unexpected read answer");
            end else begin
                if ((reg_rdata_o & msk_q[0]) !== exp_q[0]) fail_msg("read data mismatch");
                exp_q.delete(0);
                msk_q.delete(0);
            end
        end
    end
    // Event counters: wake pulses, low pin cycles, bytes toward the MAC
    always @(posedge core_clk_i) begin
        if (remote_wake_o === 1'b1) wake_n++;
        if (activity_light_pin_o === 1'b0) low_n++;
        if (mac_rx_valid_o === 1'b1) rxv_n++;
        if (mac_rx_valid_o === 1'b1 && mac_rx_byte_o !== rx_prev) fail_msg("forwarded byte wrong");
        rx_prev <= rx_byte_i;
    end

    initial begin
        void'($urandom(32'h2718));
        for (k = 0; k < 6; k++) addr[8 * k +: 8] = 8'($urandom % 255);
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        foreach (offs[i]) rd(offs[i], RESET_VALUE, 16'hffff);
        wr(16'h0100, 16'hffff);
        rd(16'h0100, 16'h0000, 16'hffff); // Unmapped offset reads zero
        wr(OFS_ADDR_HI, addr[47:32]);
        wr(OFS_ADDR_MID, addr[31:16]);
        wr(OFS_ADDR_LO, addr[15:0]);
        rd(OFS_ADDR_HI, addr[47:32], 16'hffff);
        rd(OFS_ADDR_LO, addr[15:0], 16'hffff);
        add_misc(12); add_pat(6, 16); go(1'b1, 0, 0);
        wr(OFS_WAKE_CONTROL, 16'h0004);
        check(rxv_n > 0, "receive bytes not forwarded");
        add_misc(12); add_pat(6, 16); go(1'b0, 0, 0);
        add_misc(12); add_pat(6, 15); add_misc(3); go(1'b1, 1, 0);
        add_misc(12); add_pat(5, 16); go(1'b1, 0, 0);
        add_misc(12); add_pat(6, 16); go(1'b1, 2, 1);
        add_misc(12); add_pat(6, 8); go(1'b1, 0, 0);
        add_pat(6, 8); go(1'b1, 0, 0);
        add_misc(12); add_pat(6, 7); src.fq.push_back(addr[47:40]); // Break inside a copy
        src.fq.push_back(~addr[39:32]); add_pat(7, 16); go(1'b1, 0, 1);
        add_pat(6, 16); go(1'b1, 0, 1);
        wr(OFS_WAKE_CONTROL, 16'h8004); // Drop the level left by earlier frames
        // Pulse mode, every width code
        for (w = 0; w < 4; w++) begin
            wr(OFS_WAKE_IRQ_CONFIG, 16'h0080 | 16'(w << PULSE_WIDTH_LSB));
            add_misc(20); add_pat(6, 16); go(1'b1, 0, 1);
            repeat ((w + 1) * PULSE_UNIT_CYC + 10) @(posedge core_clk_i);
            check(low_n == (w + 1) * PULSE_UNIT_CYC, "pulse width wrong");
        end
        wr(OFS_INT_ENABLE, 16'h0040);
        add_misc(8); add_pat(6, 16); go(1'b1, 0, 1);
        check(general_irq_pin_n_o === 1'b0, "general interrupt not raised");
        rd(OFS_INT_STATUS, 16'h0040, 16'h0040);
        check(general_irq_pin_n_o === 1'b1, "general interrupt not cleared");
        rd(OFS_INT_STATUS, 16'h0000, 16'h0040);
        // Level mode: only the status write releases the pins
        wr(OFS_WAKE_IRQ_CONFIG, 16'h0000);
        add_misc(8); add_pat(6, 16); go(1'b1, 0, 1);
        rd(OFS_INT_STATUS, 16'h0040, 16'h0040);
        repeat (300) @(posedge core_clk_i);
        check(activity_light_pin_o === 1'b0, "level wake released early");
        check(general_irq_pin_n_o === 1'b0, "level general released by read");
        rd(OFS_WAKE_CONTROL, 16'h8004, 16'h8004);
        wr(OFS_WAKE_CONTROL, 16'h8004);
        repeat (3) @(posedge core_clk_i);
        check(activity_light_pin_o === 1'b1 && general_irq_pin_n_o === 1'b1, "level not cleared");
        // Isolate: MAC side floats, transmit ignored
        mac_tx_en_i <= 1'b1;
        mac_tx_byte_i <= 8'($urandom);
        wr(OFS_BASIC_CONTROL, 16'h0400);
        repeat (2) @(posedge core_clk_i);
        rxv_n = 0;
        add_misc(8); go(1'b1, 0, 0);
        check(mac_rx_oe_o === 1'b0 && line_tx_en_o === 1'b0, "isolate not applied");
        check(line_tx_byte_o === 8'h00 && rxv_n == 0, "isolate leaks data");
        wr(OFS_BASIC_CONTROL, 16'h0000);
        repeat (2) @(posedge core_clk_i);
        check(line_tx_en_o === 1'b1 && line_tx_byte_o === mac_tx_byte_i, "transmit not passed");
        // Software reset clears registers but keeps the latched strap
        wake_strap_pad_i <= 1'b0;
        wr(OFS_BASIC_CONTROL, 16'h8000);
        rd(OFS_WAKE_CONTROL, 16'h0000, 16'hffff);
        check(activity_light_pin_o === 1'b1, "strap relatched by software reset");
        // Hardware reset with the strap low: pin returns to activity
        resetn_i <= 1'b0;
        wake_strap_pad_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check(mac_rx_oe_o === 1'b0 && general_irq_pin_n_o === 1'b1, "reset levels wrong");
        resetn_i <= 1'b1;
        activity_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check(activity_light_pin_o === 1'b1, "activity not shown");
        activity_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        check(activity_light_pin_o === 1'b0, "activity not followed");
        check(exp_q.size() == 0, "read answers missing");
        end_of_test();
    end
endmodule
`default_nettype wire
